//--- rtl/ssr_receive.sv
// Purpose: Receive path and select arbitration of a four-wire serial unit
// Assumes: Link pins arrive asynchronously and pass two flops first
// Notes: Transmit path is not present; slave output echoes last word
`timescale 1ns/1ps
module ssr_receive (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // Register port
  input ssr_pkg::ssr_bus_req_t req,
  output logic [7:0] rd_data,
  // Serial link
  input ssr_pkg::ssr_link_in_t lin,
  output ssr_pkg::ssr_link_out_t lout,
  // Request lines
  output logic rx_full_irq,
  output logic overrun_irq
);
  import ssr_pkg::*;

  function automatic logic [15:0] len_mask(input logic [4:0] n);
    len_mask = 16'hffff >> (LEN_MAX - n);
  endfunction

  function automatic logic [15:0] bit_rev(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15 - i];
    end
    bit_rev = r;
  endfunction

  function automatic logic reg_hit(input ssr_bus_req_t r,
                                   input logic [15:0] a);
    reg_hit = (r.addr == a);
  endfunction

  function automatic logic [4:0] clamp_len(input logic [7:0] v);
    if (v < {3'h0, LEN_MIN}) begin
      clamp_len = LEN_MIN;
    end else if (v > {3'h0, LEN_MAX}) begin
      clamp_len = LEN_MAX;
    end else begin
      clamp_len = v[4:0];
    end
  endfunction

  // Register state
  logic standby, two_wire_sel, master_select, stop_one;
  logic bit_order, phase, four_wire, cs_cfg_hi;
  logic tx_en, rx_en, rx_ie, rx_full, overrun, conflict, arb_ok;
  logic [15:0] rx_data, rx_sh, tx_sh;
  logic [4:0] len, bit_cnt;
  logic [5:0] edge_cnt;
  logic [3:0] half_cnt, arb_cnt;
  logic sck_q, sck_prev;
  logic [2:0] sync1, sync2;
  logic [7:0] rd_mux;
  ssr_state_t state, next_state;
  ssr_link_out_t next_lout;

  // Pin synchronisers; first stage feeds only the second
  wire [2:0] pin_raw = {lin.sck, lin.sdi, lin.scs_n};
  genvar g;
  for (g = 0; g < 3; g++) begin : g_sync
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        sync1[g] <= 1'b1;
        sync2[g] <= 1'b1;
      end else if (ce) begin
        sync1[g] <= pin_raw[g];
        sync2[g] <= sync1[g];
      end
    end
  end

  // Access decode
  wire active = !two_wire_sel;
  wire in_range = req.addr >= ADDR_RANGE_LO && req.addr <= ADDR_RANGE_HI;
  wire acc_ok = !(standby && in_range);
  wire wr_en = ce && req.wr_stb && acc_ok;
  wire wr_standby = wr_en && reg_hit(req, ADDR_STANDBY);
  wire wr_func = wr_en && reg_hit(req, ADDR_FUNC_SEL);
  wire wr_ctrl = wr_en && reg_hit(req, ADDR_CTRL_HIGH);
  wire wr_mode = wr_en && reg_hit(req, ADDR_MODE);
  wire wr_enable = wr_en && reg_hit(req, ADDR_ENABLE);
  wire wr_status = wr_en && reg_hit(req, ADDR_STATUS);
  wire wr_mode_two = wr_en && reg_hit(req, ADDR_MODE_TWO);
  wire wr_bitcnt = wr_en && reg_hit(req, ADDR_BIT_COUNT);
  wire rd_rx_lo = ce && req.rd_stb && acc_ok && reg_hit(req, ADDR_RX_LO);

  // Arbitration window
  wire need_arb = four_wire && cs_cfg_hi;
  wire set_master = wr_ctrl && req.wr_data[BIT_MASTER];
  wire arb_go = set_master && !master_select && need_arb && active;
  wire arb_lost = ce && state == ST_ARB && !sync2[PIN_SCS];
  wire arb_end = ce && state == ST_ARB && arb_cnt == ARB_CYC - 4'h1;

  // Master clock engine
  wire [5:0] last_edge = {len, 1'b0} - 6'h01;
  // Gated by active so a late function switch cannot sample one more bit
  wire m_tick = ce && active && state == ST_XFER
    && half_cnt == SCK_HALF_CYC - 4'h1;
  wire m_last = m_tick && edge_cnt == last_edge;
  wire m_sample = m_tick && (edge_cnt[0] != phase);
  wire keep_going = rx_en && !stop_one && !conflict;

  // Slave edge detect on the synchronised clock
  wire s_rise = sync2[PIN_SCK] && !sck_prev;
  wire s_fall = !sync2[PIN_SCK] && sck_prev;
  wire s_sample = phase ? s_fall : s_rise;
  wire s_launch = phase ? s_rise : s_fall;
  wire slave_sel = !master_select && active && !sync2[PIN_SCS];

  // Shared sampling path
  wire sample_evt = master_select ? m_sample
    : ce && slave_sel && rx_en && !overrun && s_sample;
  wire done = sample_evt && bit_cnt == len - 5'h01;
  wire ovr_evt = done && rx_full;
  wire store = done && !rx_full;
  wire lsb_first = bit_order && !four_wire;
  wire [15:0] word_msb = {rx_sh[14:0], sync2[PIN_SDI]} & len_mask(len);
  wire [15:0] word = lsb_first ? bit_rev(word_msb) >> (LEN_MAX - len)
                               : word_msb;

  // Frame start; dummy read or further read while enabled
  wire start_frame = ce && state == ST_IDLE && rd_rx_lo && master_select
    && arb_ok && rx_en && !overrun && !conflict && active
    && !arb_go;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (arb_go) begin
          next_state = ST_ARB;
        end else if (start_frame) begin
          next_state = ST_XFER;
        end
      end
      ST_ARB: begin
        if (arb_lost || arb_end || !master_select) begin
          next_state = ST_IDLE;
        end
      end
      ST_XFER: begin
        if (ovr_evt || !master_select || !active) begin
          next_state = ST_IDLE;
        end else if (m_last && !keep_going) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= ST_IDLE;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // Timing counters
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      half_cnt <= 4'h0;
      edge_cnt <= 6'h00;
      arb_cnt <= 4'h0;
      sck_q <= 1'b1;
      sck_prev <= 1'b1;
    end else if (ce) begin
      half_cnt <= (state != ST_XFER || m_tick) ? 4'h0 : half_cnt + 4'h1;
      edge_cnt <= (state != ST_XFER || m_last) ? 6'h00
                : m_tick ? edge_cnt + 6'h01 : edge_cnt;
      arb_cnt <= (state == ST_ARB) ? arb_cnt + 4'h1 : 4'h0;
      sck_q <= (next_state != ST_XFER) ? 1'b1 : m_tick ? ~sck_q : sck_q;
      sck_prev <= sync2[PIN_SCK];
    end
  end

  // Shift registers and bit counter
  wire cnt_clear = start_frame || m_last
    || (!master_select && sync2[PIN_SCS]);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bit_cnt <= 5'h00;
      rx_sh <= 16'h0000;
      tx_sh <= 16'h0000;
    end else if (ce) begin
      bit_cnt <= (cnt_clear || done) ? 5'h00
               : sample_evt ? bit_cnt + 5'h01 : bit_cnt;
      rx_sh <= sample_evt ? {rx_sh[14:0], sync2[PIN_SDI]} : rx_sh;
      if (sync2[PIN_SCS]) begin
        tx_sh <= rx_data << (LEN_MAX - len);
      end else if (slave_sel && s_launch) begin
        tx_sh <= {tx_sh[14:0], 1'b0};
      end
    end
  end

  // Flags; hardware set wins over clear, receive enable leaves them alone
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_full <= 1'b0;
      overrun <= 1'b0;
      conflict <= 1'b0;
      rx_data <= 16'h0000;
    end else if (ce) begin
      if (store) begin
        rx_full <= 1'b1;
        rx_data <= word;
      end else if (rd_rx_lo) begin
        rx_full <= 1'b0;
      end
      if (ovr_evt) begin
        overrun <= 1'b1;
      end else if (wr_status && !req.wr_data[BIT_OVERRUN]) begin
        overrun <= 1'b0;
      end
      if (arb_lost) begin
        conflict <= 1'b1;
      end else if (wr_status && !req.wr_data[BIT_CONFLICT]) begin
        conflict <= 1'b0;
      end
    end
  end

  // Control registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      standby <= 1'b0;
      two_wire_sel <= 1'b0;
      master_select <= 1'b0;
      stop_one <= 1'b0;
      arb_ok <= 1'b0;
    end else if (ce) begin
      if (wr_standby) standby <= req.wr_data[BIT_STANDBY];
      if (wr_func) two_wire_sel <= req.wr_data[BIT_TWO_WIRE];
      if (wr_ctrl) stop_one <= req.wr_data[BIT_STOP_ONE];
      if (arb_lost) begin
        master_select <= 1'b0;
      end else if (wr_ctrl) begin
        master_select <= req.wr_data[BIT_MASTER];
      end
      if (arb_lost || (wr_ctrl && !req.wr_data[BIT_MASTER])) begin
        arb_ok <= 1'b0;
      end else if (arb_end || (set_master && !need_arb)) begin
        arb_ok <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bit_order <= 1'b0;
      phase <= 1'b0;
      four_wire <= 1'b0;
      cs_cfg_hi <= 1'b0;
      tx_en <= 1'b0;
      rx_en <= 1'b0;
      rx_ie <= 1'b0;
      len <= LEN_MIN;
    end else if (ce) begin
      if (wr_mode) begin
        bit_order <= req.wr_data[BIT_ORDER];
        phase <= req.wr_data[BIT_PHASE];
      end
      if (wr_mode_two) begin
        four_wire <= req.wr_data[BIT_FOUR_WIRE];
        cs_cfg_hi <= req.wr_data[BIT_CS_CFG_HI];
      end
      if (wr_enable) begin
        tx_en <= req.wr_data[BIT_TX_EN];
        rx_en <= req.wr_data[BIT_RX_EN];
        rx_ie <= req.wr_data[BIT_RX_IE];
      end
      if (wr_bitcnt) len <= clamp_len(req.wr_data);
    end
  end

  // Read mux; blocked range reads as zero
  always_comb begin
    rd_mux = 8'h00;
    case (req.addr)
      ADDR_STANDBY: rd_mux[BIT_STANDBY] = standby;
      ADDR_FUNC_SEL: rd_mux[BIT_TWO_WIRE] = two_wire_sel;
      ADDR_CTRL_HIGH: begin
        rd_mux[BIT_MASTER] = master_select;
        rd_mux[BIT_STOP_ONE] = stop_one;
      end
      ADDR_MODE: begin
        rd_mux[BIT_ORDER] = bit_order;
        rd_mux[BIT_PHASE] = phase;
      end
      ADDR_MODE_TWO: begin
        rd_mux[BIT_FOUR_WIRE] = four_wire;
        rd_mux[BIT_CS_CFG_HI] = cs_cfg_hi;
      end
      ADDR_ENABLE: begin
        rd_mux[BIT_TX_EN] = tx_en;
        rd_mux[BIT_RX_EN] = rx_en;
        rd_mux[BIT_RX_IE] = rx_ie;
      end
      ADDR_STATUS: begin
        rd_mux[BIT_OVERRUN] = overrun;
        rd_mux[BIT_RX_FULL] = rx_full;
        rd_mux[BIT_CONFLICT] = conflict;
      end
      ADDR_RX_LO: rd_mux = rx_data[7:0];
      ADDR_RX_HI: rd_mux = rx_data[15:8];
      ADDR_BIT_COUNT: rd_mux = {3'h0, len};
      default: rd_mux = 8'h00;
    endcase
    if (!acc_ok) begin
      rd_mux = 8'h00;
    end
  end

  // Pin drive; enables low while driving
  always_comb begin
    next_lout.sck = sck_q;
    next_lout.sck_oe_n = !(master_select && active);
    next_lout.sdo = tx_sh[15];
    next_lout.sdo_oe_n = !slave_sel;
    next_lout.scs_n = !(state == ST_XFER);
    next_lout.scs_n_oe_n = !(master_select && active && need_arb && arb_ok);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_data <= 8'h00;
      lout <= LINK_IDLE;
      rx_full_irq <= 1'b0;
      overrun_irq <= 1'b0;
    end else if (ce) begin
      rd_data <= req.rd_stb ? rd_mux : 8'h00;
      lout <= next_lout;
      rx_full_irq <= rx_full && rx_ie;
      overrun_irq <= overrun && rx_ie;
    end
  end

  // Checks
  rx_irq_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(rx_full) && rx_ie && ce |=> rx_full_irq)
    else $error("receive request missing after full flag");
  read_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    rd_rx_lo && !done |=> !rx_full)
    else $error("full flag survived a data read");
  full_set_a: assert property (@(posedge ref_clk) disable iff (rst)
    store |=> rx_full && rx_data == $past(word))
    else $error("frame not stored");
  ovr_stop_a: assert property (@(posedge ref_clk) disable iff (rst)
    ovr_evt |=> overrun && state == ST_IDLE)
    else $error("overrun did not stop the unit");
  ovr_refuse_a: assert property (@(posedge ref_clk) disable iff (rst)
    overrun |-> !start_frame && !sample_evt)
    else $error("reception while overrun set");
  arb_lose_a: assert property (@(posedge ref_clk) disable iff (rst)
    arb_lost |=> conflict && !master_select && state == ST_IDLE)
    else $error("lost arbitration not handled");
  conflict_block_a: assert property (@(posedge ref_clk) disable iff (rst)
    conflict |-> !start_frame)
    else $error("transfer started during conflict");
  slave_quiet_a: assert property (@(posedge ref_clk) disable iff (rst)
    !master_select && sync2[PIN_SCS] && ce |=> lout.sdo_oe_n)
    else $error("slave drove data while deselected");
  stop_one_a: assert property (@(posedge ref_clk) disable iff (rst)
    m_last && stop_one |=> state == ST_IDLE [*2])
    else $error("clock ran past one word");
  standby_a: assert property (@(posedge ref_clk) disable iff (rst)
    req.rd_stb && ce && standby && in_range |=> rd_data == 8'h00)
    else $error("read served during standby");
  func_sel_a: assert property (@(posedge ref_clk) disable iff (rst)
    two_wire_sel |-> !start_frame && !sample_evt)
    else $error("unit active with two-wire function selected");
  master_clk_a: assert property (@(posedge ref_clk) disable iff (rst)
    state == ST_XFER && ce |=> !lout.sck_oe_n)
    else $error("master not driving clock in frame");
  start_a: assert property (@(posedge ref_clk) disable iff (rst)
    start_frame |=> state == ST_XFER && edge_cnt == 6'h00)
    else $error("dummy read did not start a frame");
  phase_mid_a: assert property (@(posedge ref_clk) disable iff (rst)
    done && master_select && phase |-> edge_cnt != last_edge)
    else $error("phase one flags not set mid frame");
  len_range_a: assert property (@(posedge ref_clk) disable iff (rst)
    len >= LEN_MIN && len <= LEN_MAX)
    else $error("frame length out of range");
endmodule

//--- rtl/ssr_pkg.sv
// Purpose: Shared constants and types for the serial receive block
// Assumes: 100 MHz ref_clk, 8-bit register port, 16-bit address
// Notes: Link pins are three inputs and three outputs with their enables, carried in packed structs
package ssr_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SCK_HALF_NS = 80;
  localparam int unsigned ARB_NS = 40;
  localparam logic [3:0] SCK_HALF_CYC =
    4'((SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] ARB_CYC =
    4'((ARB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] ADDR_STANDBY = 16'h0008;
  localparam logic [15:0] ADDR_FUNC_SEL = 16'h018c;
  localparam logic [15:0] ADDR_RANGE_LO = 16'h0193;
  localparam logic [15:0] ADDR_RANGE_HI = 16'h019d;
  localparam logic [15:0] ADDR_CTRL_HIGH = 16'h0193;
  localparam logic [15:0] ADDR_MODE = 16'h0194;
  localparam logic [15:0] ADDR_ENABLE = 16'h0195;
  localparam logic [15:0] ADDR_STATUS = 16'h0196;
  localparam logic [15:0] ADDR_MODE_TWO = 16'h0197;
  localparam logic [15:0] ADDR_RX_LO = 16'h0199;
  localparam logic [15:0] ADDR_RX_HI = 16'h019a;
  localparam logic [15:0] ADDR_BIT_COUNT = 16'h019b;
  localparam int BIT_STANDBY = 3;
  localparam int BIT_TWO_WIRE = 0;
  localparam int BIT_MASTER = 6;
  localparam int BIT_STOP_ONE = 5;
  localparam int BIT_ORDER = 7;
  localparam int BIT_PHASE = 0;
  localparam int BIT_FOUR_WIRE = 7;
  localparam int BIT_CS_CFG_HI = 5;
  localparam int BIT_TX_EN = 7;
  localparam int BIT_RX_EN = 6;
  localparam int BIT_RX_IE = 3;
  localparam int BIT_OVERRUN = 6;
  localparam int BIT_RX_FULL = 1;
  localparam int BIT_CONFLICT = 0;
  localparam int PIN_SCK = 2;
  localparam int PIN_SDI = 1;
  localparam int PIN_SCS = 0;
  localparam logic [4:0] LEN_MIN = 5'h08;
  localparam logic [4:0] LEN_MAX = 5'h10;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wr_data;
    logic wr_stb;
    logic rd_stb;
  } ssr_bus_req_t;
  typedef struct packed {
    logic sck;
    logic sdi;
    logic scs_n;
  } ssr_link_in_t;
  typedef struct packed {
    logic sck;
    logic sck_oe_n;
    logic sdo;
    logic sdo_oe_n;
    logic scs_n;
    logic scs_n_oe_n;
  } ssr_link_out_t;
  localparam ssr_link_out_t LINK_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
  typedef enum logic [1:0] {ST_IDLE, ST_ARB, ST_XFER} ssr_state_t;
endpackage

//--- verification/ssr_far_slave.sv
// Purpose: Far-side slave that answers the unit's receive clocks
// Assumes: Clock and select lines have pull-ups when nobody drives them
// Notes: Data line shows the inverse of its last bit while deselected
`timescale 1ns/1ps
module ssr_far_slave (
  // Near-side pins
  input ssr_pkg::ssr_link_out_t lout,
  // Bench control
  input wire logic [15:0] word,
  input wire logic [4:0] len,
  input wire logic phase,
  input wire logic grab,
  // Pins seen by the unit
  output ssr_pkg::ssr_link_in_t lin
);
  import ssr_pkg::*;
  logic sdi = 1'b1;
  int cnt = 0;
  wire logic sck_line;
  wire logic scs_line;
  // Pull-ups hold released lines high; grab mimics a rival master
  assign sck_line = lout.sck_oe_n ? 1'b1 : lout.sck;
  assign scs_line = grab ? 1'b0 : (lout.scs_n_oe_n ? 1'b1 : lout.scs_n);
  assign lin = {sck_line, sdi, scs_line};
  task automatic shift_out();
    sdi = word[int'(len) - 1 - cnt];
    cnt = (cnt + 1 == int'(len)) ? 0 : cnt + 1;
  endtask
  // Data moves on the edge the unit does not sample on
  always @(negedge scs_line) if (phase) shift_out();
  always @(negedge lout.sck) if (!scs_line && !phase) shift_out();
  always @(posedge lout.sck) if (!scs_line && phase) shift_out();
  // Deselected: no stale bit left on the line
  always @(posedge scs_line) begin
    cnt = 0;
    sdi = ~sdi;
  end
endmodule

//--- verification/ssr_receive_bench.sv
// Purpose: Self-checking bench for the serial receive block
// Assumes: ce held high; far side is a slave answering receive clocks
// Notes: Expected read data queue is drained by a separate monitor
`timescale 1ns/1ps
module ssr_receive_bench;
  import ssr_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  ssr_bus_req_t req = '0;
  logic [7:0] rd_data;
  ssr_link_in_t lin;
  ssr_link_out_t lout;
  logic rx_full_irq;
  logic overrun_irq;
  logic [15:0] far_word = 16'h0000;
  logic [4:0] far_len = 5'h08;
  logic far_phase = 1'b0;
  logic far_grab = 1'b0;
  logic [7:0] exp_q[$];
  logic rd_seen = 1'b0;
  logic sck_q = 1'b1;
  logic [15:0] xs_state = 16'h0048;
  logic [7:0] last = 8'h00;
  logic [15:0] w1;
  logic [15:0] w2;
  int n_rise = 0;
  int base = 0;
  int n_errors = 0;
  int samples_checked = 0;

  always #5 ref_clk = ~ref_clk;

  ssr_receive uut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .req(req),
    .rd_data(rd_data), .lin(lin), .lout(lout),
    .rx_full_irq(rx_full_irq), .overrun_irq(overrun_irq));
  ssr_far_slave far (.lout(lout), .word(far_word), .len(far_len),
    .phase(far_phase), .grab(far_grab), .lin(lin));

  function automatic logic [15:0] xs();
    xs_state = xs_state ^ (xs_state << 7);
    xs_state = xs_state ^ (xs_state >> 9);
    xs_state = xs_state ^ (xs_state << 8);
    return xs_state;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic done(input string s);
    $display("test finished: %s", s);
  endtask

  // One bus cycle; the next call overwrites, so no strobe is set twice
  task automatic bus(input logic w, input logic r, input logic [15:0] a,
                     input logic [7:0] d);
    req <= '{a, d, w, r};
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 16'h0000, 8'h00);
  endtask
  // Master writes from slave rerun arbitration, so let the window close
  task automatic ctrl(input logic [7:0] d);
    wr(ADDR_CTRL_HIGH, d);
    idle(8);
  endtask
  task automatic edges(input int n, input int e);
    idle(n);
    @(negedge ref_clk);
    check(16'(n_rise - base), 16'(e));
    @(posedge ref_clk);
  endtask
  task automatic wait_irq(input logic which, input int e);
    int k;
    k = 0;
    idle(2);
    @(negedge ref_clk);
    while ((which ? overrun_irq : rx_full_irq) !== 1'b1 && k < 2000) begin
      @(negedge ref_clk);
      k++;
    end
    check(16'(k < 2000), 16'h0001);
    repeat (4) @(negedge ref_clk);
    if (!which) check(16'(n_rise - base), 16'(e));
    @(posedge ref_clk);
  endtask

  // Results: read data one cycle after the strobe, sck rises counted
  always @(posedge ref_clk) begin
    sck_q <= lout.sck;
    if (lout.sck === 1'b1 && sck_q === 1'b0) n_rise <= n_rise + 1;
    if (rd_seen) check({8'h00, rd_data}, {8'h00, exp_q.pop_front()});
    rd_seen <= req.rd_stb;
  end

  // Whole run needs well under 10k cycles
  initial begin
    #200000;
    n_errors++;
    print_verdict();
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(ADDR_STANDBY, 8'h00);
    rd(ADDR_FUNC_SEL, 8'h00);
    rd(ADDR_BIT_COUNT, 8'h08);
    rd(16'h0100, 8'h00);
    done("reset values");
    wr(ADDR_MODE_TWO, 8'ha0);
    far_grab <= 1'b1;
    idle(4);
    ctrl(8'h40);
    rd(ADDR_STATUS, 8'h01);
    rd(ADDR_CTRL_HIGH, 8'h00);
    wr(ADDR_ENABLE, 8'h48);
    base = n_rise;
    rd(ADDR_RX_LO, 8'h00);
    edges(100, 0);
    check(16'(lout.sdo_oe_n), 16'h0000);
    far_grab <= 1'b0;
    wr(ADDR_STATUS, 8'h00);
    wr(ADDR_ENABLE, 8'h00);
    ctrl(8'h60);
    rd(ADDR_STATUS, 8'h00);
    check(16'(lout.sdo_oe_n), 16'h0001);
    check(16'(lout.scs_n_oe_n), 16'h0000);
    done("arbitration");
    wr(ADDR_STANDBY, 8'h08);
    rd(ADDR_STANDBY, 8'h08);
    rd(ADDR_CTRL_HIGH, 8'h00);
    wr(ADDR_CTRL_HIGH, 8'h00);
    wr(ADDR_STANDBY, 8'h00);
    rd(ADDR_CTRL_HIGH, 8'h60);
    done("standby");
    wr(ADDR_FUNC_SEL, 8'h01);
    rd(ADDR_FUNC_SEL, 8'h01);
    wr(ADDR_ENABLE, 8'h48);
    base = n_rise;
    rd(ADDR_RX_LO, 8'h00);
    edges(100, 0);
    wr(ADDR_FUNC_SEL, 8'h00);
    wr(ADDR_ENABLE, 8'h00);
    done("function select");
    for (int ph = 0; ph < 2; ph++) begin
      w1 = xs();
      far_word <= w1;
      far_phase <= ph[0];
      wr(ADDR_MODE, {7'h00, ph[0]});
      ctrl(8'h60);
      wr(ADDR_ENABLE, 8'h48);
      base = n_rise;
      rd(ADDR_RX_LO, last);
      wait_irq(1'b0, 8 - ph);
      edges(100, 8);
      rd(ADDR_STATUS, 8'h02);
      wr(ADDR_ENABLE, 8'h08);
      ctrl(8'h40);
      rd(ADDR_STATUS, 8'h02);
      rd(ADDR_RX_LO, w1[7:0]);
      rd(ADDR_STATUS, 8'h00);
      edges(50, 8);
      last = w1[7:0];
    end
    done("single words");
    w1 = xs();
    w2 = xs();
    far_word <= w1;
    far_phase <= 1'b0;
    far_len <= 5'h0c;
    wr(ADDR_MODE, 8'h80);
    wr(ADDR_BIT_COUNT, 8'h0c);
    ctrl(8'h60);
    wr(ADDR_ENABLE, 8'h48);
    base = n_rise;
    rd(ADDR_RX_LO, last);
    wait_irq(1'b0, 12);
    far_word <= w2;
    rd(ADDR_RX_HI, {4'h0, w1[11:8]});
    rd(ADDR_RX_LO, w1[7:0]);
    wait_irq(1'b0, 24);
    wr(ADDR_ENABLE, 8'h08);
    ctrl(8'h40);
    rd(ADDR_RX_HI, {4'h0, w2[11:8]});
    rd(ADDR_RX_LO, w2[7:0]);
    last = w2[7:0];
    done("long words");
    w1 = xs();
    far_word <= w1;
    far_len <= 5'h08;
    wr(ADDR_BIT_COUNT, 8'h08);
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_ENABLE, 8'h48);
    rd(ADDR_RX_LO, last);
    wait_irq(1'b1, 0);
    rd(ADDR_STATUS, 8'h42);
    base = n_rise;
    rd(ADDR_RX_LO, w1[7:0]);
    edges(100, 0);
    rd(ADDR_STATUS, 8'h40);
    wr(ADDR_ENABLE, 8'h08);
    wr(ADDR_STATUS, 8'h00);
    rd(ADDR_STATUS, 8'h00);
    done("overrun");
    idle(2);
    print_verdict();
  end
endmodule
